// ==== ifs_monitor.v ====
// Fault status monitor: status indicator, error sources, APB registers.
// Assumes sensor readings arrive on SYS_CLK from a local converter; remote,
// module-present and fan pins are asynchronous and are synchronised here.
//
// Contract
// - Indicator dark when idle and ready
// - Indicator green while analysis runs
// - Indicator yellow while waiting or self-testing
// - Indicator red on any detected error
// - Error always aborts running analysis
// - Error lights red, logs, reports status
// - Low remote shutdown input raises error
// - Remote not-ready after one minute: error
// - Not-ready beyond threshold in sequence: timeout
// - Missing configured module raises sync error
// - Leak from leak versus compensation reading
// - Leak current below limit: sensor open
// - Leak current above limit: sensor short
// - Compensation resistance above limit: open
// - Compensation resistance below limit: short
// - Fan under two rps over five s
`timescale 1ns/1ps
`include "ifs_regs.vh"

module ifs_monitor
#(
  parameter NUM_MOD     = 4,
  parameter SENSE_W     = 12,
  parameter HALL_PPR    = 1,
  parameter SEC_CYCLES  = `IFS_SEC_CYCLES
)
(
  input  wire               SYS_CLK,
  input  wire               RESETN,
  input  wire               PSEL,
  input  wire               PENABLE,
  input  wire               PWRITE,
  input  wire [7:0]         PADDR,
  input  wire [31:0]        PWDATA,
  output reg  [31:0]        PRDATA,
  output reg                PREADY,
  output reg                PSLVERR,
  input  wire               REMOTE_SHDN_N,
  input  wire               REMOTE_NRDY_N,
  input  wire [NUM_MOD-1:0] MOD_PRESENT,
  input  wire               FAN_HALL,
  input  wire               SENSE_VALID,
  input  wire [SENSE_W-1:0] LEAK_CUR,
  input  wire [SENSE_W-1:0] COMP_RES,
  output reg                LED_GREEN,
  output reg                LED_YELLOW,
  output reg                LED_RED,
  output reg                ANALYSIS_ABORT,
  output reg                LOG_STB,
  output reg  [`IFS_NUM_ERR-1:0] LOG_CODE
);

  localparam [3:0] ST_PRERUN = 4'h1;
  localparam [3:0] ST_RUN    = 4'h2;
  localparam [3:0] ST_NRDY   = 4'h4;
  localparam [3:0] ST_ERR    = 4'h8;
  localparam [31:0] SEC_LAST = SEC_CYCLES - 1;
  localparam [7:0] FAN_MIN   = `IFS_FAN_MIN_RPS * HALL_PPR;

  // ****************************************
  // Synchronisers
  // ****************************************
  reg [NUM_MOD+2:0] sync1_reg;
  reg [NUM_MOD+2:0] sync2_reg;
  reg               hall_d_reg;
  wire              shdn_n   = sync2_reg[0];
  wire              rnrdy    = ~sync2_reg[1];
  wire              hall     = sync2_reg[2];
  wire [NUM_MOD-1:0] present = sync2_reg[NUM_MOD+2:3];

  always @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sync1_reg  <= {(NUM_MOD+3){1'b1}};
      sync2_reg  <= {(NUM_MOD+3){1'b1}};
      hall_d_reg <= 1'b1; // Same as the synchroniser, so no false edge
    end
    else
    begin
      sync1_reg  <= {MOD_PRESENT, FAN_HALL, REMOTE_NRDY_N, REMOTE_SHDN_N};
      sync2_reg  <= sync1_reg;
      hall_d_reg <= hall;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  reg        run_reg;
  reg        wait_reg;
  reg        selftest_reg;
  reg        seq_reg;
  reg [15:0] tmo_reg;
  reg [31:0] leak_lim_reg;
  reg [31:0] comp_lim_reg;
  reg [SENSE_W-1:0] leak_dlt_reg;
  reg [NUM_MOD-1:0] mod_mask_reg;
  reg [7:0]  fan_rps_reg;
  reg [3:0]  state_reg;
  reg [`IFS_NUM_ERR-1:0] err_reg;

  wire wr = PSEL & PENABLE & PREADY & PWRITE;
  wire notready = wait_reg | selftest_reg | rnrdy;

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = hit(a, `IFS_OFS_CTRL) | hit(a, `IFS_OFS_STATUS) |
               hit(a, `IFS_OFS_ERRFLAGS) | hit(a, `IFS_OFS_TMO) |
               hit(a, `IFS_OFS_LEAK_LIM) | hit(a, `IFS_OFS_COMP_LIM) |
               hit(a, `IFS_OFS_LEAK_DLT) | hit(a, `IFS_OFS_MOD_MASK) |
               hit(a, `IFS_OFS_FAN_RPS);
    end
  endfunction

  reg [31:0] rdata;
  always @*
  begin
    rdata = 32'h0000_0000;
    case (PADDR)
      `IFS_OFS_CTRL:     rdata[4:0] = {seq_reg, selftest_reg, wait_reg, 1'b0, run_reg};
      `IFS_OFS_STATUS:   rdata[5:0] = {notready, run_reg, state_reg};
      `IFS_OFS_ERRFLAGS: rdata[`IFS_NUM_ERR-1:0] = err_reg;
      `IFS_OFS_TMO:      rdata[15:0] = tmo_reg;
      `IFS_OFS_LEAK_LIM: rdata = leak_lim_reg;
      `IFS_OFS_COMP_LIM: rdata = comp_lim_reg;
      `IFS_OFS_LEAK_DLT: rdata[SENSE_W-1:0] = leak_dlt_reg;
      `IFS_OFS_MOD_MASK: rdata[NUM_MOD-1:0] = mod_mask_reg;
      `IFS_OFS_FAN_RPS:  rdata[7:0] = fan_rps_reg;
      default:           rdata = 32'h0000_0000;
    endcase
  end

  // Zero wait: ready rises in the access phase, data is captured at setup
  always @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~mapped(PADDR);
      if (PSEL & ~PENABLE & ~PWRITE)
        PRDATA <= rdata;
    end
  end

  always @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wait_reg     <= 1'b0;
      selftest_reg <= 1'b0;
      seq_reg      <= 1'b0;
      tmo_reg      <= `IFS_RST_TMO;
      leak_lim_reg <= `IFS_RST_LEAK_LIM;
      comp_lim_reg <= `IFS_RST_COMP_LIM;
      leak_dlt_reg <= `IFS_RST_LEAK_DLT;
      mod_mask_reg <= `IFS_RST_MOD_MASK;
    end
    else if (wr)
    begin
      case (PADDR)
        `IFS_OFS_CTRL:
        begin
          wait_reg     <= PWDATA[`IFS_CTRL_WAIT];
          selftest_reg <= PWDATA[`IFS_CTRL_SELFTEST];
          seq_reg      <= PWDATA[`IFS_CTRL_SEQ];
        end
        `IFS_OFS_TMO:      tmo_reg      <= PWDATA[15:0];
        `IFS_OFS_LEAK_LIM: leak_lim_reg <= PWDATA;
        `IFS_OFS_COMP_LIM: comp_lim_reg <= PWDATA;
        `IFS_OFS_LEAK_DLT: leak_dlt_reg <= PWDATA[SENSE_W-1:0];
        `IFS_OFS_MOD_MASK: mod_mask_reg <= PWDATA[NUM_MOD-1:0];
        default:           tmo_reg      <= tmo_reg;
      endcase
    end
  end

  // ****************************************
  // Second tick and timers
  // ****************************************
  reg [31:0] sec_cnt_reg;
  reg        tick_reg;
  reg [7:0]  rt_sec_reg;
  reg        rt_arm_reg;
  reg [15:0] nr_sec_reg;
  reg [7:0]  fan_cnt_reg;
  reg [2:0]  fan_low_reg;
  wire start = wr & hit(PADDR, `IFS_OFS_CTRL) & PWDATA[`IFS_CTRL_START];
  wire stop  = wr & hit(PADDR, `IFS_OFS_CTRL) & PWDATA[`IFS_CTRL_STOP];
  wire fan_low = fan_cnt_reg < FAN_MIN;

  always @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sec_cnt_reg <= 32'h0000_0000;
      tick_reg    <= 1'b0;
      rt_sec_reg  <= 8'h00;
      rt_arm_reg  <= 1'b0;
      nr_sec_reg  <= 16'h0000;
      fan_cnt_reg <= 8'h00;
      fan_low_reg <= 3'h0;
      fan_rps_reg <= 8'h00;
    end
    else
    begin
      tick_reg    <= (sec_cnt_reg == SEC_LAST);
      sec_cnt_reg <= (sec_cnt_reg == SEC_LAST) ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
      // Remote window restarts with each analysis start
      if (start & ~run_reg)
      begin
        rt_arm_reg <= 1'b1;
        rt_sec_reg <= 8'h00;
      end
      else if (~run_reg | (rt_sec_reg == `IFS_REMOTE_TMO_S))
        rt_arm_reg <= 1'b0;
      else if (tick_reg & rt_arm_reg)
        rt_sec_reg <= rt_sec_reg + 8'h01;
      if (~(run_reg & seq_reg & notready))
        nr_sec_reg <= 16'h0000;
      else if (tick_reg & (nr_sec_reg != 16'hFFFF))
        nr_sec_reg <= nr_sec_reg + 16'h0001;
      // Hall pulses counted per one-second window
      if (tick_reg)
      begin
        fan_rps_reg <= fan_cnt_reg;
        fan_cnt_reg <= {7'h00, hall & ~hall_d_reg};
        if (!fan_low)
          fan_low_reg <= 3'h0;
        else if (fan_low_reg != `IFS_FAN_LOW_S)
          fan_low_reg <= fan_low_reg + 3'h1;
      end
      else if (hall & ~hall_d_reg & (fan_cnt_reg != 8'hFF))
        fan_cnt_reg <= fan_cnt_reg + 8'h01;
    end
  end

  // ****************************************
  // Error sources
  // ****************************************
  reg [`IFS_NUM_ERR-1:0] err_set;
  reg [`IFS_NUM_ERR-1:0] err_clr;
  wire [SENSE_W-1:0] leak_lo = leak_lim_reg[SENSE_W-1:0];
  wire [SENSE_W-1:0] leak_hi = leak_lim_reg[SENSE_W+15:16];
  wire [SENSE_W-1:0] comp_lo = comp_lim_reg[SENSE_W-1:0];
  wire [SENSE_W-1:0] comp_hi = comp_lim_reg[SENSE_W+15:16];
  wire               sense_ok = SENSE_VALID & (LEAK_CUR >= leak_lo) & (LEAK_CUR <= leak_hi)
                                & (COMP_RES >= comp_lo) & (COMP_RES <= comp_hi);

  always @*
  begin
    err_set = {`IFS_NUM_ERR{1'b0}};
    err_set[`IFS_ERR_SHDN]   = ~shdn_n;
    err_set[`IFS_ERR_RTMO]   = rt_arm_reg & (rt_sec_reg == `IFS_REMOTE_TMO_S) & rnrdy;
    err_set[`IFS_ERR_TMO]    = nr_sec_reg > tmo_reg;
    err_set[`IFS_ERR_SYNC]   = |(mod_mask_reg & ~present);
    // Solvent cooling pulls the leak reading below the ambient reference
    err_set[`IFS_ERR_LEAK]   = sense_ok & (COMP_RES > LEAK_CUR)
                               & ((COMP_RES - LEAK_CUR) > leak_dlt_reg);
    err_set[`IFS_ERR_LOPEN]  = SENSE_VALID & (LEAK_CUR < leak_lo);
    err_set[`IFS_ERR_LSHORT] = SENSE_VALID & (LEAK_CUR > leak_hi);
    err_set[`IFS_ERR_COPEN]  = SENSE_VALID & (COMP_RES > comp_hi);
    err_set[`IFS_ERR_CSHORT] = SENSE_VALID & (COMP_RES < comp_lo);
    err_set[`IFS_ERR_FAN]    = tick_reg & fan_low & (fan_low_reg == `IFS_FAN_LOW_S);
    err_clr = (wr & hit(PADDR, `IFS_OFS_ERRFLAGS)) ? PWDATA[`IFS_NUM_ERR-1:0]
                                                   : {`IFS_NUM_ERR{1'b0}};
  end

  // ****************************************
  // Flags, run control and indicator
  // ****************************************
  reg [3:0] state_next;
  wire [`IFS_NUM_ERR-1:0] err_next = (err_reg & ~err_clr) | err_set;
  wire                    err_any  = |err_next;

  always @*
  begin
    case (1'b1)
      err_any:             state_next = ST_ERR;
      notready:            state_next = ST_NRDY;
      run_reg & ~stop:     state_next = ST_RUN;
      default:             state_next = ST_PRERUN;
    endcase
  end

  always @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      err_reg        <= {`IFS_NUM_ERR{1'b0}};
      run_reg        <= 1'b0;
      state_reg      <= ST_PRERUN;
      LED_GREEN      <= 1'b0;
      LED_YELLOW     <= 1'b0;
      LED_RED        <= 1'b0;
      ANALYSIS_ABORT <= 1'b0;
      LOG_STB        <= 1'b0;
      LOG_CODE       <= {`IFS_NUM_ERR{1'b0}};
    end
    else
    begin
      // A set in the same cycle as its clear keeps the flag
      err_reg <= err_next;
      // An error start request is refused; an error always ends the run
      if (err_any | stop)
        run_reg <= 1'b0;
      else if (start)
        run_reg <= 1'b1;
      ANALYSIS_ABORT <= err_any & run_reg;
      LOG_STB        <= |(err_set & ~err_reg);
      LOG_CODE       <= err_set & ~err_reg;
      state_reg      <= state_next;
      LED_RED        <= state_next == ST_ERR;
      LED_YELLOW     <= state_next == ST_NRDY;
      LED_GREEN      <= state_next == ST_RUN;
    end
  end

endmodule

// ==== ifs_regs.vh ====
// Register map, reset values and timing counts of the fault status monitor.
// Assumes a 32-bit APB with byte addresses; all registers are aligned words.
`ifndef IFS_REGS_VH
`define IFS_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define IFS_OFS_CTRL      8'h00
`define IFS_OFS_STATUS    8'h04
`define IFS_OFS_ERRFLAGS  8'h08
`define IFS_OFS_TMO       8'h0C
`define IFS_OFS_LEAK_LIM  8'h10
`define IFS_OFS_COMP_LIM  8'h14
`define IFS_OFS_LEAK_DLT  8'h18
`define IFS_OFS_MOD_MASK  8'h1C
`define IFS_OFS_FAN_RPS   8'h20

// ****************************************
// Field positions
// ****************************************
`define IFS_CTRL_START    0
`define IFS_CTRL_STOP     1
`define IFS_CTRL_WAIT     2
`define IFS_CTRL_SELFTEST 3
`define IFS_CTRL_SEQ      4
`define IFS_ERR_SHDN      0
`define IFS_ERR_RTMO      1
`define IFS_ERR_TMO       2
`define IFS_ERR_SYNC      3
`define IFS_ERR_LEAK      4
`define IFS_ERR_LOPEN     5
`define IFS_ERR_LSHORT    6
`define IFS_ERR_COPEN     7
`define IFS_ERR_CSHORT    8
`define IFS_ERR_FAN       9
`define IFS_NUM_ERR       10

// ****************************************
// Reset values
// ****************************************
// Sized to the register fields at their default widths
`define IFS_RST_TMO       16'h003C
`define IFS_RST_LEAK_LIM  32'h0F00_0100
`define IFS_RST_COMP_LIM  32'h0F00_0100
`define IFS_RST_LEAK_DLT  12'h080
`define IFS_RST_MOD_MASK  4'h0

// ****************************************
// Timing
// ****************************************
`define IFS_CLK_PERIOD_NS 25
`define IFS_SECOND_NS     1000000000
`define IFS_SEC_CYCLES    (`IFS_SECOND_NS / `IFS_CLK_PERIOD_NS)
`define IFS_REMOTE_TMO_S  60
`define IFS_FAN_LOW_S     5
`define IFS_FAN_MIN_RPS   2

`endif

// ==== ifs_monitor_checker.sv ====
// Port checks on the fault status monitor.
// Assumes one clock domain and the zero-wait APB answer of this block.
`timescale 1ns/1ps
`include "ifs_regs.vh"
module ifs_monitor_checker (
  input wire logic                    SYS_CLK,
  input wire logic                    RESETN,
  input wire logic                    PSEL,
  input wire logic                    PENABLE,
  input wire logic                    PREADY,
  input wire logic                    REMOTE_SHDN_N,
  input wire logic                    LED_GREEN,
  input wire logic                    LED_YELLOW,
  input wire logic                    LED_RED,
  input wire logic                    ANALYSIS_ABORT,
  input wire logic                    LOG_STB,
  input wire logic [`IFS_NUM_ERR-1:0] LOG_CODE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  chk_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  chk_red_first: assert property (LED_RED |-> !LED_YELLOW && !LED_GREEN)
    else $error("red shown with another colour");
  chk_yellow_over: assert property (LED_YELLOW |-> !LED_GREEN)
    else $error("yellow shown with green");
  chk_abort_red: assert property (ANALYSIS_ABORT |-> LED_RED ##1 !ANALYSIS_ABORT)
    else $error("abort without error");
  chk_log_red: assert property (LOG_STB |-> LED_RED && LOG_CODE != 0)
    else $error("log entry without red");
  chk_log_quiet: assert property (!LOG_STB |-> LOG_CODE == 0)
    else $error("log code without strobe");
  // Two sync stages plus the flag edge, one cycle spare
  chk_shdn_red: assert property (!REMOTE_SHDN_N [*4] |=> LED_RED)
    else $error("shutdown not shown red");
endmodule
bind ifs_monitor ifs_monitor_checker chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .REMOTE_SHDN_N(REMOTE_SHDN_N),
  .LED_GREEN(LED_GREEN), .LED_YELLOW(LED_YELLOW), .LED_RED(LED_RED),
  .ANALYSIS_ABORT(ANALYSIS_ABORT), .LOG_STB(LOG_STB), .LOG_CODE(LOG_CODE));

// ==== ifs_far_model.sv ====
// Far side: remote instruments, system modules, fan and sensor front end.
// Assumes bench-set levels; a fan period of 0 is a stalled fan.
`timescale 1ns/1ps
module ifs_far_model (
  input  wire logic        clk,
  input  wire logic        shdn_req,
  input  wire logic        nrdy_req,
  input  wire logic [3:0]  pres_req,
  input  wire logic [7:0]  fan_per,
  input  wire logic [11:0] leak_val,
  input  wire logic [11:0] comp_val,
  output logic             shdn_n,
  output logic             nrdy_n,
  output logic [3:0]       present,
  output logic             hall,
  output logic             valid,
  output logic [11:0]      leak,
  output logic [11:0]      comp
);
  logic [7:0] cnt = 8'h00;
  assign shdn_n = !shdn_req;
  assign nrdy_n = !nrdy_req;
  assign present = pres_req;
  assign valid = (cnt[1:0] == 2'h0);
  // Readings off the strobe are junk, so stale values cannot pass
  assign leak = valid ? leak_val : ~leak_val;
  assign comp = valid ? comp_val : ~comp_val;
  assign hall = (fan_per != 8'h00) && (cnt < {1'b0, fan_per[7:1]});
  always @(posedge clk)
    cnt <= (fan_per == 8'h00 || cnt >= fan_per - 8'h01) ? 8'h00 : cnt + 8'h01;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the fault status monitor.
// Assumes SEC_CYCLES cut to 20 so seconds pass quickly.
`timescale 1ns/1ps
`include "ifs_regs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  localparam int SEC = 20;
  logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, fan_per = 8'h08;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, err_q, shdn_n, nrdy_n, hall, valid, g, y, r, abort, lstb;
  logic        shdn_c = 1'b0, nrdy_c = 1'b0;
  logic [3:0]  pres_c = 4'hF, present;
  logic [11:0] leak_c = 12'h800, comp_c = 12'h800, leak, comp;
  logic [9:0]  lcode, log_seen = 10'h0;
  int          fail_count = 0, comparisons = 0, aborts = 0, cycles = 0, i;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h24, 8'h10, 8'h14};
  logic [31:0] rv [8] = '{32'h0, 32'h1, 32'h0, 32'h3C, 32'h80, 32'h0, 32'h0F000100,
    32'h0F000100};
  // Rows: leak reading, compensation reading, flags expected
  logic [33:0] srow [6] = '{{12'h0FF, 12'h800, 10'h020}, {12'hF01, 12'h800, 10'h040},
    {12'h800, 12'hF01, 10'h080}, {12'h800, 12'h0FF, 10'h100},
    {12'h200, 12'h281, 10'h010}, {12'h200, 12'h280, 10'h000}};
  ifs_monitor #(.SEC_CYCLES(SEC)) dut (.SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .REMOTE_SHDN_N(shdn_n), .REMOTE_NRDY_N(nrdy_n),
    .MOD_PRESENT(present), .FAN_HALL(hall), .SENSE_VALID(valid), .LEAK_CUR(leak),
    .COMP_RES(comp), .LED_GREEN(g), .LED_YELLOW(y), .LED_RED(r), .ANALYSIS_ABORT(abort),
    .LOG_STB(lstb), .LOG_CODE(lcode));
  ifs_far_model far (.clk(sys_clk), .shdn_req(shdn_c), .nrdy_req(nrdy_c), .pres_req(pres_c),
    .fan_per(fan_per), .leak_val(leak_c), .comp_val(comp_c), .shdn_n(shdn_n), .nrdy_n(nrdy_n),
    .present(present), .hall(hall), .valid(valid), .leak(leak), .comp(comp));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (lstb === 1'b1)
      log_seen <= log_seen | lcode;
    if (abort === 1'b1)
      aborts++;
    if (cycles == 4000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic show(input string n);
    $display("test %s over", n);
  endtask
  // Entered just after an edge; ends one idle edge after the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic errs(input logic [9:0] e);
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd_q, {22'h0, e})
    `CHK(log_seen, e)
    apb(1'b1, 8'h08, 32'h3FF);
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd_q, 32'h0)
    log_seen = 10'h0;
  endtask
  task automatic wait_red(input int n, input logic e);
    repeat (n) @(posedge sys_clk);
    `CHK(r, e)
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    `CHK({r, y, g}, 3'b000)
    for (i = 0; i < 8; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      `CHK(rd_q, rv[i])
      `CHK(err_q, i == 5)
    end
    for (i = 0; i < 6; i++)
    begin
      {leak_c, comp_c} <= srow[i][33:10];
      repeat (8) @(posedge sys_clk);
      leak_c <= 12'h800;
      comp_c <= 12'h800;
      errs(srow[i][9:0]);
    end
    show("rows");
    apb(1'b1, 8'h00, 32'h1);
    @(posedge sys_clk);
    `CHK({r, y, g}, 3'b001)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd_q, 32'h12)
    for (i = 2; i < 4; i++)
    begin
      apb(1'b1, 8'h00, 32'h1 << i);
      @(posedge sys_clk);
      `CHK({r, y, g}, 3'b010)
    end
    apb(1'b1, 8'h00, 32'h0);
    shdn_c <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK({r, y, g}, 3'b100)
    `CHK(aborts, 1)
    shdn_c <= 1'b0;
    errs(10'h001);
    show("indicator");
    apb(1'b1, 8'h00, 32'h1);
    nrdy_c <= 1'b1;
    wait_red(58 * SEC, 1'b0);
    wait_red(3 * SEC, 1'b1);
    `CHK(aborts, 2)
    nrdy_c <= 1'b0;
    errs(10'h002);
    apb(1'b1, 8'h0C, 32'h3);
    apb(1'b1, 8'h00, 32'h15);
    wait_red(2 * SEC, 1'b0);
    wait_red(3 * SEC, 1'b1);
    errs(10'h004);
    show("timeouts");
    apb(1'b1, 8'h1C, 32'h1);
    pres_c <= 4'h7;
    wait_red(6, 1'b0);
    pres_c <= 4'hE;
    wait_red(6, 1'b1);
    pres_c <= 4'hF;
    errs(10'h008);
    fan_per <= 8'h00;
    wait_red(5 * SEC - 2, 1'b0);
    wait_red(2 * SEC + 10, 1'b1);
    fan_per <= 8'h08;
    repeat (3 * SEC) @(posedge sys_clk);
    errs(10'h200);
    show("sources");
    apb(1'b1, 8'h00, 32'h1);
    @(posedge sys_clk);
    `CHK({r, y, g}, 3'b001)
    apb(1'b1, 8'h00, 32'h2);
    @(posedge sys_clk);
    `CHK({r, y, g}, 3'b000)
    apb(1'b1, 8'h00, 32'h1);
    resetn <= 1'b0;
    @(posedge sys_clk);
    `CHK({r, y, g, abort, lstb}, 5'h0)
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd_q, 32'h1)
    show("reset");
    wrap_up();
  end
endmodule
